// ===== rtl/store_addr_map.vh
// Field positions, codes, address step and register map of the store address generator
// Functional notes
// - Long store opcode 100110, bank bit per operand
// - Short displacement: twenty sign copies ahead
// - Long displacement: four signs, field, extension
// - Data type from instruction bits 13..12
// - Memory stores: bytes, halfwords, word, double
// - Base not status word: base plus displacement
// - Double: second word at address plus four
// - Base status word: I/O address is displacement
// - I/O stores only word or double
// - I/O displacement: base plus displacement
// - Opcode 100111: store old base, then advance
// - Double next-address: update first, old plus four
// - Non-byte: displacement bit zero cleared for update
// - Opcode 1101110: word store, base plus four
// - Short format base is always local
// - Register-indirect word store leaves base unchanged
`ifndef STORE_ADDR_MAP_VH
`define STORE_ADDR_MAP_VH

// Instruction word: [31:16] first halfword, [15:0] second halfword
`define OPL_HI        31
`define OPL_LO        26
`define OPS_HI        31
`define OPS_LO        25
`define OP_LONG_DISP  6'h26
`define OP_LONG_NEXT  6'h27
`define OP_SHORT_POST 7'h6E
`define OP_SHORT_REG  7'h6C
`define D_BIT         25
`define S_BIT         24
`define RD_HI         23
`define RD_LO         20
`define RS_HI         19
`define RS_LO         16
`define E_BIT         15
`define SGN_BIT       14
`define DD_HI         13
`define DD_LO         12
`define DISPLACEMENT_LOW_FIELD_HI       11
`define DISPLACEMENT_LOW_FIELD_LO       0
`define SR_CODE       4'h1
`define PC_CODE       4'h0

// Data-type field
`define DD_BYTE_U     2'h0
`define DD_BYTE_S     2'h1
`define DD_HALF       2'h2
`define DD_WIDE       2'h3

// Store data types
`define T_BU          3'h0
`define T_BS          3'h1
`define T_HU          3'h2
`define T_HS          3'h3
`define T_W           3'h4
`define T_D           3'h5

// Address modes
`define M_NONE        3'h0
`define M_DISP        3'h1
`define M_IOA         3'h2
`define M_IOD         3'h3
`define M_NEXT        3'h4
`define M_POST        3'h5
`define M_REGIND      3'h6

`define WORD_STEP     32'h00000004

// Register map (byte addresses)
`define R_INSTR       8'h00
`define R_EXT         8'h04
`define R_BASE        8'h08
`define R_SRC         8'h0C
`define R_PAIR        8'h10
`define R_CTRL        8'h14
`define R_STATUS      8'h18
`define R_ADDR        8'h1C
`define R_WBVAL       8'h20
`define R_INFO        8'h24

// Control and status bits
`define CTRL_GO       0
`define ST_BUSY       0
`define ST_DONE       1
`define ST_ERR        2
`define ST_ILLEGAL    3
`define ST_MISUSE     4

`endif

// ===== rtl/store_address_generation.v
// APB-controlled store decoder and store sequencer
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "store_addr_map.vh"

module store_address_generation #(
   parameter AW = 8
) (
   input  wire          pclk,
   input  wire          presetn,
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [AW-1:0] paddr,
   input  wire [31:0]   pwdata,
   output wire [31:0]   prdata,
   output wire          pready,
   output wire          pslverr,
   output wire          st_valid,
   input  wire          st_ready,
   input  wire          st_err,
   output wire [31:0]   st_addr,
   output wire [31:0]   st_data,
   output wire [2:0]    st_type,
   output wire          st_io,
   output wire          st_second,
   output wire          wb_valid,
   output wire          wb_bank,
   output wire [3:0]    wb_index,
   output wire [31:0]   wb_value
);

   localparam [2:0] S_IDLE   = 3'b001;
   localparam [2:0] S_FIRST  = 3'b010;
   localparam [2:0] S_SECOND = 3'b100;

   // Software-loaded operands
   reg  [31:0] instr_r;
   reg  [15:0] ext_r;
   reg  [31:0] base_r;
   reg  [31:0] src_r;
   reg  [31:0] pair_r;

   // Sequencer state
   reg  [2:0]  state_r;
   reg  [2:0]  state_nxt;
   reg  [31:0] st_addr_r;
   reg  [31:0] st_data_r;
   reg  [2:0]  st_type_r;
   reg         st_io_r;
   reg         double_r;
   reg         wb_valid_r;
   reg         wb_bank_r;
   reg  [3:0]  wb_index_r;
   reg  [31:0] wb_value_r;
   reg  [31:0] last_addr_r;
   reg  [31:0] prdata_r;

   // Sticky status
   reg         done_r;
   reg         err_r;
   reg         illegal_r;
   reg         misuse_r;

   // Decoder outputs
   wire [2:0]  dec_mode;
   wire [2:0]  dec_type;
   wire        dec_double;
   wire        dec_io;
   wire [31:0] dec_addr;
   wire        dec_wb_en;
   wire [31:0] dec_wb_value;
   wire        dec_base_bank;
   wire [3:0]  dec_base_index;
   wire        dec_src_bank;
   wire [3:0]  dec_src_index;
   wire        dec_misuse;

   // Bus decode
   wire        apb_setup  = psel & ~penable;
   wire        apb_access = psel & penable;
   wire        apb_wr     = apb_access & pwrite;
   wire        busy       = ~state_r[0];
   reg         mapped;
   reg  [31:0] rd_mux;

   // Events
   wire        go_req     = apb_wr && (paddr == `R_CTRL) && pwdata[`CTRL_GO] && !busy;
   wire        go_ok      = go_req && (dec_mode != `M_NONE);
   wire        go_bad     = go_req && (dec_mode == `M_NONE);
   wire        accept     = st_valid && st_ready;
   wire        finish     = accept && (state_r == S_SECOND || st_err || !double_r);
   wire        status_wr  = apb_wr && (paddr == `R_STATUS);
   wire        op_wr      = apb_wr && !busy;

   store_decode u_decode (
      .instr      (instr_r),
      .ext        (ext_r),
      .base       (base_r),
      .mode       (dec_mode),
      .dtype      (dec_type),
      .is_double  (dec_double),
      .is_io      (dec_io),
      .addr       (dec_addr),
      .wb_en      (dec_wb_en),
      .wb_value   (dec_wb_value),
      .base_bank  (dec_base_bank),
      .base_index (dec_base_index),
      .src_bank   (dec_src_bank),
      .src_index  (dec_src_index),
      .misuse     (dec_misuse)
   );

   assign pready    = 1'b1;
   assign pslverr   = apb_access & ~mapped;
   assign prdata    = prdata_r;
   assign st_valid  = state_r[1] | state_r[2];
   assign st_addr   = st_addr_r;
   assign st_data   = st_data_r;
   assign st_type   = st_type_r;
   assign st_io     = st_io_r;
   assign st_second = state_r[2];
   assign wb_valid  = wb_valid_r;
   assign wb_bank   = wb_bank_r;
   assign wb_index  = wb_index_r;
   assign wb_value  = wb_value_r;

   // Address decode and read mux
   always @* begin
      mapped = 1'b1;
      rd_mux = 32'h00000000;
      case (paddr)
         `R_INSTR:  rd_mux = instr_r;
         `R_EXT:    rd_mux = {16'h0000, ext_r};
         `R_BASE:   rd_mux = base_r;
         `R_SRC:    rd_mux = src_r;
         `R_PAIR:   rd_mux = pair_r;
         `R_CTRL:   rd_mux = 32'h00000000;
         `R_STATUS: begin
            rd_mux[`ST_BUSY]    = busy;
            rd_mux[`ST_DONE]    = done_r;
            rd_mux[`ST_ERR]     = err_r;
            rd_mux[`ST_ILLEGAL] = illegal_r;
            rd_mux[`ST_MISUSE]  = misuse_r;
         end
         `R_ADDR:   rd_mux = last_addr_r;
         `R_WBVAL:  rd_mux = wb_value_r;
         `R_INFO:   rd_mux = {10'h000, dec_src_bank, dec_src_index, dec_base_bank,
                              dec_base_index, 1'b0, dec_wb_en, dec_io, dec_double,
                              1'b0, dec_type, 1'b0, dec_mode};
         default:   mapped = 1'b0;
      endcase
   end

   // Read data captured in the setup phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata_r <= 32'h00000000;
      else if (apb_setup && !pwrite)
         prdata_r <= rd_mux;
   end

   // Operand registers, frozen while a store runs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_r <= 32'h00000000;
         ext_r   <= 16'h0000;
         base_r  <= 32'h00000000;
         src_r   <= 32'h00000000;
         pair_r  <= 32'h00000000;
      end else if (op_wr) begin
         case (paddr)
            `R_INSTR: instr_r <= pwdata;
            `R_EXT:   ext_r   <= pwdata[15:0];
            `R_BASE:  base_r  <= pwdata;
            `R_SRC:   src_r   <= pwdata;
            `R_PAIR:  pair_r  <= pwdata;
            default:  instr_r <= instr_r;
         endcase
      end
   end

   // Store sequencer
   always @* begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE: begin
            if (go_ok)
               state_nxt = S_FIRST;
         end
         S_FIRST: begin
            if (accept)
               state_nxt = (double_r && !st_err) ? S_SECOND : S_IDLE;
         end
         S_SECOND: begin
            if (accept)
               state_nxt = S_IDLE;
         end
         default: state_nxt = S_IDLE;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r     <= S_IDLE;
         st_addr_r   <= 32'h00000000;
         st_data_r   <= 32'h00000000;
         st_type_r   <= `T_BU;
         st_io_r     <= 1'b0;
         double_r    <= 1'b0;
         last_addr_r <= 32'h00000000;
      end else begin
         state_r <= state_nxt;
         if (go_ok) begin
            st_addr_r   <= dec_addr;
            st_data_r   <= src_r;
            st_type_r   <= dec_type;
            st_io_r     <= dec_io;
            double_r    <= dec_double;
            last_addr_r <= dec_addr;
         end else if (accept && state_r == S_FIRST && double_r && !st_err) begin
            // Second word follows the old base, not the updated one
            st_addr_r <= st_addr_r + `WORD_STEP;
            st_data_r <= pair_r;
         end
      end
   end

   // Base write-back issued with the first memory cycle, before any error
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wb_valid_r <= 1'b0;
         wb_bank_r  <= 1'b0;
         wb_index_r <= 4'h0;
         wb_value_r <= 32'h00000000;
      end else begin
         wb_valid_r <= go_ok && dec_wb_en;
         if (go_ok && dec_wb_en) begin
            wb_bank_r  <= dec_base_bank;
            wb_index_r <= dec_base_index;
            wb_value_r <= dec_wb_value;
         end
      end
   end

   // Sticky flags, write one to clear; a set in the same cycle wins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_r    <= 1'b0;
         err_r     <= 1'b0;
         illegal_r <= 1'b0;
         misuse_r  <= 1'b0;
      end else begin
         done_r    <= finish |
                      (done_r & ~(status_wr & pwdata[`ST_DONE]));
         err_r     <= (accept & st_err) |
                      (err_r & ~(status_wr & pwdata[`ST_ERR]));
         illegal_r <= go_bad |
                      (illegal_r & ~(status_wr & pwdata[`ST_ILLEGAL]));
         misuse_r  <= (go_ok & dec_misuse) |
                      (misuse_r & ~(status_wr & pwdata[`ST_MISUSE]));
      end
   end

endmodule // store_address_generation
`default_nettype wire

// ===== rtl/store_decode.v
// Decode and address arithmetic of one store instruction
`timescale 1ns/10ps
`default_nettype none
`include "store_addr_map.vh"

module store_decode (
   input  wire [31:0] instr,
   input  wire [15:0] ext,
   input  wire [31:0] base,
   output reg  [2:0]  mode,
   output reg  [2:0]  dtype,
   output wire        is_double,
   output wire        is_io,
   output reg  [31:0] addr,
   output reg         wb_en,
   output reg  [31:0] wb_value,
   output wire        base_bank,
   output wire [3:0]  base_index,
   output wire        src_bank,
   output wire [3:0]  src_index,
   output wire        misuse
);

   wire [5:0]  op_long    = instr[`OPL_HI:`OPL_LO];
   wire [6:0]  op_short   = instr[`OPS_HI:`OPS_LO];
   wire        is_long    = (op_long == `OP_LONG_DISP) || (op_long == `OP_LONG_NEXT);
   wire        is_short   = (op_short == `OP_SHORT_POST) || (op_short == `OP_SHORT_REG);
   wire        sgn        = instr[`SGN_BIT];
   wire [1:0]  dd         = instr[`DD_HI:`DD_LO];
   wire [11:0] displacement_low_field       = instr[`DISPLACEMENT_LOW_FIELD_HI:`DISPLACEMENT_LOW_FIELD_LO];
   wire        base_is_sr = ~instr[`D_BIT] && (instr[`RD_HI:`RD_LO] == `SR_CODE);
   wire        base_is_pc = ~instr[`D_BIT] && (instr[`RD_HI:`RD_LO] == `PC_CODE);
   reg  [31:0] dis_raw;
   reg  [31:0] dis_eff;

   // Bank bit per operand; short format base always local
   assign base_bank  = is_long ? instr[`D_BIT] : 1'b1;
   assign base_index = instr[`RD_HI:`RD_LO];
   assign src_bank   = instr[`S_BIT];
   assign src_index  = instr[`RS_HI:`RS_LO];
   assign is_double  = (dtype == `T_D);
   assign is_io      = (mode == `M_IOA) || (mode == `M_IOD);
   assign misuse     = (mode == `M_NEXT) && (base_is_sr || base_is_pc);

   always @* begin
      if (instr[`E_BIT])
         dis_raw = {{4{sgn}}, displacement_low_field, ext};
      else
         dis_raw = {{20{sgn}}, displacement_low_field};
      // Low displacement bits select signedness, size and space
      case (dd)
         `DD_BYTE_U: dtype = `T_BU;
         `DD_BYTE_S: dtype = `T_BS;
         `DD_HALF:   dtype = dis_raw[0] ? `T_HS : `T_HU;
         default:    dtype = dis_raw[0] ? `T_D : `T_W;
      endcase
      if (!is_long)
         dtype = `T_W;
      case (dd)
         `DD_HALF: dis_eff = {dis_raw[31:1], 1'b0};
         `DD_WIDE: begin
            // Bit one is a space code only outside next-address mode
            if (op_long == `OP_LONG_NEXT)
               dis_eff = {dis_raw[31:1], 1'b0};
            else
               dis_eff = {dis_raw[31:2], 2'b00};
         end
         default:  dis_eff = dis_raw;
      endcase
      mode = `M_NONE;
      if (is_long && op_long == `OP_LONG_NEXT)
         mode = `M_NEXT;
      else if (is_long && dd == `DD_WIDE && dis_raw[1])
         mode = base_is_sr ? `M_IOA : `M_IOD;
      else if (is_long && !base_is_sr)
         mode = `M_DISP;
      else if (is_short && op_short == `OP_SHORT_POST)
         mode = `M_POST;
      else if (is_short)
         mode = `M_REGIND;
      wb_en    = 1'b0;
      wb_value = base;
      case (mode)
         `M_DISP:   addr = base + dis_eff;
         `M_IOD:    addr = base + dis_eff;
         `M_IOA:    addr = dis_eff;
         `M_NEXT: begin
            addr     = base;
            wb_en    = 1'b1;
            wb_value = base + dis_eff;
         end
         `M_POST: begin
            addr     = base;
            wb_en    = 1'b1;
            wb_value = base + `WORD_STEP;
         end
         `M_REGIND: addr = base;
         default:   addr = 32'h00000000;
      endcase
   end

endmodule // store_decode
`default_nettype wire

// ===== testbench/store_address_generation_monitor.sv
// Port assertions for the store address generator
`timescale 1ns/10ps
`default_nettype none
`include "store_addr_map.vh"
module store_address_generation_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        st_valid,
   input wire logic        st_ready,
   input wire logic        st_err,
   input wire logic [31:0] st_addr,
   input wire logic [31:0] st_data,
   input wire logic [2:0]  st_type,
   input wire logic        st_io,
   input wire logic        st_second,
   input wire logic        wb_valid,
   input wire logic [31:0] wb_value
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_pair;
      st_valid && st_ready && !st_err && !st_second && st_type == `T_D
      |=> st_valid && st_second && st_addr == $past(st_addr) + `WORD_STEP;
   endproperty
   a_pair: assert property (p_pair) else $error("second word address wrong");
   property p_sec_dbl;
      st_valid && st_second |-> st_type == `T_D;
   endproperty
   a_sec_dbl: assert property (p_sec_dbl) else $error("second word not double");
   property p_abort;
      st_valid && st_ready && st_err && !st_second |=> !st_valid;
   endproperty
   a_abort: assert property (p_abort) else $error("store went on after error");
   property p_io_type;
      st_valid && st_io |-> st_type == `T_W || st_type == `T_D;
   endproperty
   a_io_type: assert property (p_io_type) else $error("io store of narrow type");
   property p_type;
      st_valid |-> st_type <= `T_D;
   endproperty
   a_type: assert property (p_type) else $error("undefined store type");
   property p_hold;
      st_valid && !st_ready |=> st_valid && $stable(st_addr) && $stable(st_data);
   endproperty
   a_hold: assert property (p_hold) else $error("request changed before accept");
   property p_wb_pulse;
      wb_valid |=> !wb_valid;
   endproperty
   a_wb_pulse: assert property (p_wb_pulse) else $error("write-back longer than a cycle");
   property p_wb_first;
      wb_valid |-> $rose(st_valid) && !st_second;
   endproperty
   a_wb_first: assert property (p_wb_first) else $error("write-back not at first word");
   property p_wb_even;
      wb_valid && st_type != `T_BU && st_type != `T_BS |-> wb_value[0] == st_addr[0];
   endproperty
   a_wb_even: assert property (p_wb_even) else $error("odd step on wide update");
endmodule // store_address_generation_monitor
bind store_address_generation store_address_generation_monitor u_mon (
   .pclk(pclk), .presetn(presetn), .st_valid(st_valid), .st_ready(st_ready),
   .st_err(st_err), .st_addr(st_addr), .st_data(st_data), .st_type(st_type),
   .st_io(st_io), .st_second(st_second), .wb_valid(wb_valid), .wb_value(wb_value)
);
`default_nettype wire

// ===== testbench/store_address_generation_tb.sv
// Self-checking bench for the store address generator
`timescale 1ns/10ps
`default_nettype none
`include "store_addr_map.vh"
`define CHK(nm, e, g) begin \
   num_checks++; \
   if ((g) !== (e)) begin \
      bad_count++; \
      $display("ERROR %s expected %h seen %h", nm, e, g); \
   end \
end
module store_address_generation_tb;
   localparam logic [31:0] SRC_V = 32'h1111AAAA;
   localparam logic [31:0] PAIR_V = 32'h2222BBBB;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
   logic        st_valid, st_ready, st_err, st_io, st_second, wb_valid, wb_bank, err_req, w_bank;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, st_addr, st_data, wb_value, rdat, w_val;
   logic [2:0]  st_type;
   logic [3:0]  wb_index, w_idx, wait_n;
   logic [31:0] s_addr [0:3];
   logic [31:0] s_data [0:3];
   logic [2:0]  s_type [0:3];
   logic        s_io [0:3];
   logic        s_sec [0:3];
   int          n, wn, bad_count, num_checks, k;
   store_address_generation #(.AW(8)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .st_valid(st_valid), .st_ready(st_ready), .st_err(st_err), .st_addr(st_addr),
      .st_data(st_data), .st_type(st_type), .st_io(st_io), .st_second(st_second),
      .wb_valid(wb_valid), .wb_bank(wb_bank), .wb_index(wb_index), .wb_value(wb_value)
   );
   store_bus_partner u_bus (
      .pclk(pclk), .presetn(presetn), .st_valid(st_valid), .st_second(st_second),
      .wait_n(wait_n), .err_req(err_req), .st_ready(st_ready), .st_err(st_err)
   );
   always #12.5 pclk = ~pclk;
   always @(posedge pclk) begin
      if (st_valid === 1'b1 && st_ready === 1'b1 && n < 4) begin
         s_addr[n] <= st_addr;
         s_data[n] <= st_data;
         s_type[n] <= st_type;
         s_io[n] <= st_io;
         s_sec[n] <= st_second;
         n <= n + 1;
      end
      if (wb_valid === 1'b1) begin
         w_bank <= wb_bank;
         w_idx <= wb_index;
         w_val <= wb_value;
         wn <= wn + 1;
      end
   end
   function automatic logic [31:0] li(input logic [5:0] op, input logic d, input logic [3:0] rd,
      input logic [3:0] rs, input logic e, input logic sg, input logic [1:0] dd,
      input logic [11:0] ds);
      li = {op, d, 1'b0, rd, rs, e, sg, dd, ds};
   endfunction
   function automatic logic [31:0] si(input logic [6:0] op, input logic s, input logic [3:0] ld);
      si = {op, s, ld, 4'h2, 16'h0000};
   endfunction
   task tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task run(input logic [31:0] ins, input logic [15:0] ex, input logic [31:0] b);
      n = 0;
      wn = 0;
      apb(1'b1, `R_STATUS, 32'h0000001E);
      apb(1'b1, `R_INSTR, ins);
      apb(1'b1, `R_EXT, {16'h0000, ex});
      apb(1'b1, `R_BASE, b);
      apb(1'b1, `R_CTRL, 32'h00000001);
      apb(1'b0, `R_STATUS, 32'h0);
      while (rdat[`ST_BUSY] !== 1'b0) apb(1'b0, `R_STATUS, 32'h0);
   endtask
   task cst(input int i, input logic [31:0] a, input logic [2:0] t, input logic io);
      `CHK("st_addr", a, s_addr[i])
      `CHK("st_data", (i == 0) ? SRC_V : PAIR_V, s_data[i])
      `CHK("st_type", t, s_type[i])
      `CHK("st_io", io, s_io[i])
      `CHK("st_second", (i == 1), s_sec[i])
   endtask
   task cwb(input logic bk, input logic [3:0] ix, input logic [31:0] v);
      `CHK("wb_count", 1, wn)
      `CHK("wb_bank", bk, w_bank)
      `CHK("wb_index", ix, w_idx)
      `CHK("wb_value", v, w_val)
   endtask
   task nxt(input logic d, input logic [1:0] dd, input logic sg, input logic [11:0] ds,
      input logic [31:0] dl, input logic [2:0] t);
      run(li(6'h27, d, 4'h3, 4'h2, 1'b0, sg, dd, ds), 16'h0000, 32'h00003000);
      cst(0, 32'h00003000, t, 1'b0);
      cwb(d, 4'h3, 32'h00003000 + dl);
   endtask
   initial begin
      repeat (8000) @(posedge pclk);
      bad_count++;
      tally_and_finish();
   end
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      wait_n = 4'h0;
      err_req = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `R_STATUS, 32'h0);
      `CHK("status_reset", 32'h0, rdat)
      apb(1'b0, 8'h80, 32'h0);
      `CHK("pslverr", 1'b1, rerr)
      apb(1'b1, `R_SRC, SRC_V);
      apb(1'b1, `R_PAIR, PAIR_V);
      run(li(6'h26, 1'b0, 4'h2, 4'h3, 1'b0, 1'b1, 2'h3, 12'hFF8), 16'h0000, 32'h00001000);
      cst(0, 32'h00000FF8, `T_W, 1'b0);
      apb(1'b0, `R_INFO, 32'h0);
      `CHK("info_regs", {1'b0, 4'h3, 1'b0, 4'h2}, rdat[21:12])
      wait_n <= 4'h3;
      run(li(6'h26, 1'b0, 4'h2, 4'h3, 1'b1, 1'b1, 2'h3, 12'hFFF), 16'hFF01, 32'h00000080);
      cst(0, 32'hFFFFFF80, `T_D, 1'b0);
      cst(1, 32'hFFFFFF84, `T_D, 1'b0);
      wait_n <= 4'h0;
      for (k = 0; k < 4; k++) begin
         run(li(6'h26, 1'b0, 4'h2, 4'h3, 1'b0, 1'b0, (k < 2) ? k[1:0] : 2'h2,
            k[0] ? 12'h011 : 12'h010), 16'h0000, 32'h00001000);
         cst(0, (k == 1) ? 32'h00001011 : 32'h00001010, k[2:0], 1'b0);
      end
      run(li(6'h26, 1'b0, `SR_CODE, 4'h3, 1'b0, 1'b0, 2'h3, 12'h106), 16'h0000, 32'hDEAD0000);
      cst(0, 32'h00000104, `T_W, 1'b1);
      run(li(6'h26, 1'b1, 4'h7, 4'h3, 1'b0, 1'b0, 2'h3, 12'h00F), 16'h0000, 32'h00002000);
      cst(0, 32'h0000200C, `T_D, 1'b1);
      cst(1, 32'h00002010, `T_D, 1'b1);
      nxt(1'b0, 2'h0, 1'b0, 12'h00F, 32'h0000000F, `T_BU);
      nxt(1'b1, 2'h2, 1'b0, 12'h00F, 32'h0000000E, `T_HS);
      nxt(1'b1, 2'h3, 1'b1, 12'hFF8, 32'hFFFFFFF8, `T_W);
      nxt(1'b1, 2'h3, 1'b0, 12'h006, 32'h00000006, `T_W);
      err_req <= 1'b1;
      nxt(1'b1, 2'h3, 1'b0, 12'h011, 32'h00000010, `T_D);
      `CHK("aborted_count", 1, n)
      apb(1'b0, `R_STATUS, 32'h0);
      `CHK("err_flag", 1'b1, rdat[`ST_ERR])
      err_req <= 1'b0;
      nxt(1'b1, 2'h3, 1'b0, 12'h011, 32'h00000010, `T_D);
      cst(1, 32'h00003004, `T_D, 1'b0);
      err_req <= 1'b1;
      run(si(7'h6E, 1'b1, 4'h9), 16'h0000, 32'hFFFFFFFC);
      cst(0, 32'hFFFFFFFC, `T_W, 1'b0);
      cwb(1'b1, 4'h9, 32'h00000000);
      err_req <= 1'b0;
      run(si(7'h6C, 1'b0, 4'h9), 16'h0000, 32'h00005554);
      cst(0, 32'h00005554, `T_W, 1'b0);
      `CHK("wb_none", 0, wn)
      `CHK("done_flag", 1'b1, rdat[`ST_DONE])
      run(li(6'h26, 1'b0, `SR_CODE, 4'h3, 1'b0, 1'b0, 2'h3, 12'h004), 16'h0000, 32'h0);
      `CHK("no_store", 0, n)
      `CHK("illegal", 1'b1, rdat[`ST_ILLEGAL])
      tally_and_finish();
   end
endmodule // store_address_generation_tb
`default_nettype wire

// ===== testbench/store_bus_partner.sv
// Memory and I/O bus model that accepts store words
`timescale 1ns/10ps
`default_nettype none
module store_bus_partner (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       st_valid,
   input  wire logic       st_second,
   input  wire logic [3:0] wait_n,
   input  wire logic       err_req,
   output var  logic       st_ready,
   output var  logic       st_err
);
   logic [3:0] cnt;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 4'h0;
         st_ready <= 1'b0;
         st_err <= 1'b0;
      end else if (st_valid && !st_ready && cnt == wait_n) begin
         st_ready <= 1'b1;
         st_err <= err_req && !st_second;
         cnt <= 4'h0;
      end else begin
         st_ready <= 1'b0;
         // Meaningless outside an accept
         st_err <= ~st_err;
         cnt <= (st_valid && !st_ready) ? cnt + 4'h1 : 4'h0;
      end
   end
endmodule // store_bus_partner
`default_nettype wire
